// *** bench/radio_link_alarm_delay_calib_bench.sv ***
// self-checking bench for the link supervisor
`timescale 1ns/100ps
`default_nettype none

module radio_link_alarm_delay_calib_bench
  import rla_pkg::*;
;
  logic clk, rst, sig_ok, aneg, lock, fr_on, hold, al_on, df_on, meas_en;
  logic fstart, far_al, far_df;
  logic [3:0] service_access_point, mstart, mstop;
  logic [31:0] iq, iq_o;
  rla_cm_type cm_tx, cm_rx;
  rla_alarm_type alarm;
  logic remote_alarm_flag, tx_df, fcs_v, rx_done, rx_err, s_done, s_to;
  logic [3:0][15:0] dly;
  logic [3:0] dval;
  logic [16:0] rtd;
  logic [15:0] frame_check_sequence;
  logic [7:0] msg[$];
  int errors, total_checks, cycles;

  rla_link_supervisor #(.SYNC_LIMIT(8)) rla_link_supervisor_inst (
    .SYS_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .RX_SIGNAL_OK_I(sig_ok),
    .RX_FRAME_START_I(fstart), .RX_REMOTE_ALARM_I(far_al), .RX_DEFECT_I(far_df),
    .SAP_FAULT_I(service_access_point), .MEAS_EN_I(meas_en), .MEAS_START_I(mstart), .MEAS_STOP_I(mstop),
    .CM_TX_I(cm_tx), .CM_RX_I(cm_rx), .IQ_I(iq), .ANEG_DONE_I(aneg), .FREQ_LOCK_I(lock),
    .ALARM_O(alarm), .TX_REMOTE_ALARM_O(remote_alarm_flag), .TX_DEFECT_O(tx_df), .DELAY_O(dly),
    .DELAY_VALID_O(dval), .SAMPLE_RTD_O(rtd), .CM_TX_FCS_O(frame_check_sequence), .CM_TX_FCS_VALID_O(fcs_v),
    .CM_RX_DONE_O(rx_done), .CM_RX_FCS_ERR_O(rx_err), .IQ_O(iq_o), .SYNC_DONE_O(s_done),
    .SYNC_TIMEOUT_O(s_to));

  rla_far_end_model rla_far_end_model_inst (.clk_i(clk), .rst_i(rst), .frames_on_i(fr_on),
    .hold_i(hold), .alarm_on_i(al_on), .defect_on_i(df_on), .frame_start_o(fstart),
    .remote_alarm_o(far_al), .defect_o(far_df));

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic t_los;
    sig_ok = 1'b1;
    cyc(8);
    chk("los clear", 0, alarm.signal_lost);
    sig_ok = 1'b0;
    cyc(1);
    sig_ok = 1'b1;
    cyc(8);
    chk("los glitch", 0, alarm.signal_lost);
    sig_ok = 1'b0;
    cyc(8);
    chk("los set", 1, alarm.signal_lost);
    chk("rai on los", 1, remote_alarm_flag);
    sig_ok = 1'b1;
    cyc(8);
  endtask

  task automatic t_frame;
    fr_on = 1'b1;
    cyc(600);
    chk("lof clear", 0, alarm.frame_lost);
    chk("rai clear", 0, remote_alarm_flag);
    al_on = 1'b1;
    df_on = 1'b1;
    cyc(3);
    chk("far alarm", 1, alarm.remote_alarm);
    chk("far defect", 1, alarm.defect);
    hold = 1'b1;
    cyc(1280);
    chk("lof set", 1, alarm.frame_lost);
    chk("rai on lof", 1, remote_alarm_flag);
    chk("alarm masked", 0, alarm.remote_alarm);
    chk("defect masked", 0, alarm.defect);
    hold = 1'b0;
    al_on = 1'b0;
    df_on = 1'b0;
    cyc(600);
    chk("lof regained", 0, alarm.frame_lost);
  endtask

  task automatic t_delay;
    // a start with measurement disabled must not arm the channel
    meas_en   = 1'b0;
    mstart[0] = 1'b1;
    cyc(1);
    meas_en   = 1'b1;
    mstart[0] = 1'b0;
    mstop[0]  = 1'b1;
    cyc(1);
    mstop[0] = 1'b0;
    chk("idle stop", 0, dval);
    for (int g = 0; g < 4; g++)
    begin
      mstart[g] = 1'b1;
      cyc(1);
      mstart[g] = 1'b0;
      cyc(9 + g);
      mstop[g] = 1'b1;
      cyc(1);
      mstop[g] = 1'b0;
      chk("delay valid", 1, dval[g]);
      chk("delay count", 10 + g, dly[g]);
    end
    cyc(2);
    chk("sample rtd", 25, rtd);
  endtask

  task automatic t_sample_access_point;
    for (int i = 0; i < 4; i++)
    begin
      service_access_point = 4'h1 << i;
      iq = 32'hA5C3_0F1E ^ i;
      cyc(2);
      chk("defect out", 1, tx_df);
      chk("sample pass", 32'hA5C3_0F1E ^ i, iq_o);
      service_access_point = 4'h0;
      cyc(2);
      chk("defect off", 0, tx_df);
    end
  endtask

  task automatic send(input logic rx);
    foreach (msg[i])
    begin
      if (rx)
        cm_rx = {msg[i], 1'b1, i == msg.size() - 1};
      else
        cm_tx = {msg[i], 1'b1, i == msg.size() - 1};
      cyc(1);
    end
    cm_tx = '0;
    cm_rx = '0;
  endtask

  task automatic t_fcs;
    // ascii 1..9 gives the well known check value under this polynomial and preset
    msg = {8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
    send(1'b0);
    chk("tx fcs valid", 1, fcs_v);
    chk("tx fcs", 16'h29B1, frame_check_sequence);
    msg.push_back(8'h29);
    msg.push_back(8'hB1);
    send(1'b1);
    chk("rx done", 1, rx_done);
    chk("rx good", 0, rx_err);
    msg[3] = 8'h30;
    // valid must not drop and rise again in one time step
    cyc(1);
    send(1'b1);
    chk("rx done bad", 1, rx_done);
    chk("rx bad", 1, rx_err);
  endtask

  task automatic t_sync;
    aneg = 1'b1;
    cyc(8);
    chk("no early timeout", 0, s_to);
    cyc(6);
    chk("sync timeout", 1, s_to);
    chk("not synced", 0, s_done);
    lock = 1'b1;
    cyc(4);
    chk("synced", 1, s_done);
    chk("timeout off", 0, s_to);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // hang guard well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    {rst, sig_ok, aneg, lock, fr_on, hold, al_on, df_on} = 8'h80;
    {service_access_point, mstart, mstop, iq} = '0;
    meas_en = 1'b1;
    cm_tx = '0;
    cm_rx = '0;
    cyc(6);
    rst = 1'b0;
    cyc(2);
    chk("reset los", 1, alarm.signal_lost);
    chk("reset lof", 1, alarm.frame_lost);
    chk("reset rai", 1, remote_alarm_flag);
    t_los();
    t_frame();
    t_delay();
    t_sample_access_point();
    t_fcs();
    t_sync();
    stop_test();
  end
endmodule

bind rla_link_supervisor rla_sup_checker #(.SYNC_LIMIT(SYNC_LIMIT)) rla_sup_checker_inst (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .RX_SIGNAL_OK_I(RX_SIGNAL_OK_I), .SAP_FAULT_I(SAP_FAULT_I),
  .MEAS_STOP_I(MEAS_STOP_I), .CM_TX_I(CM_TX_I), .CM_RX_I(CM_RX_I), .IQ_I(IQ_I),
  .ANEG_DONE_I(ANEG_DONE_I), .ALARM_O(ALARM_O), .TX_REMOTE_ALARM_O(TX_REMOTE_ALARM_O),
  .TX_DEFECT_O(TX_DEFECT_O), .DELAY_O(DELAY_O), .DELAY_VALID_O(DELAY_VALID_O),
  .SAMPLE_RTD_O(SAMPLE_RTD_O), .CM_TX_FCS_VALID_O(CM_TX_FCS_VALID_O), .CM_RX_DONE_O(CM_RX_DONE_O),
  .IQ_O(IQ_O), .SYNC_DONE_O(SYNC_DONE_O), .SYNC_TIMEOUT_O(SYNC_TIMEOUT_O));

`default_nettype wire

// *** bench/rla_far_end_model.sv ***
// far link endpoint model: frame boundaries and received alarm bits
`timescale 1ns/100ps
`default_nettype none

module rla_far_end_model
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic frames_on_i,
  input  wire logic hold_i,
  input  wire logic alarm_on_i,
  input  wire logic defect_on_i,
  output logic      frame_start_o,
  output logic      remote_alarm_o,
  output logic      defect_o
);
  logic [7:0] slot_q;

  // 8-bit slot counter wraps every 256 cycles, one frame period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !frames_on_i)
      slot_q <= 8'h00;
    else
      slot_q <= slot_q + 8'h01;
  end

  // hold_i drops boundaries on purpose so the receiver loses alignment
  assign frame_start_o  = frames_on_i && !hold_i && (slot_q == 8'h00);
  assign remote_alarm_o = alarm_on_i;
  assign defect_o       = defect_on_i;
endmodule

`default_nettype wire

// *** bench/rla_sup_assertions.sv ***
// assertion checker for the link supervisor ports
`timescale 1ns/100ps
`default_nettype none

module rla_sup_checker
  import rla_pkg::*;
#(
  parameter int unsigned SYNC_LIMIT = SYNC_CYC
)
(
  input wire logic                      SYS_CLK_I,
  input wire logic                      RST_I,
  input wire logic                      RX_SIGNAL_OK_I,
  input wire logic [NUM_SAP-1:0]        SAP_FAULT_I,
  input wire logic [NUM_MEAS-1:0]       MEAS_STOP_I,
  input wire rla_cm_type                CM_TX_I,
  input wire rla_cm_type                CM_RX_I,
  input wire logic [IQ_W-1:0]           IQ_I,
  input wire logic                      ANEG_DONE_I,
  input wire rla_alarm_type             ALARM_O,
  input wire logic                      TX_REMOTE_ALARM_O,
  input wire logic                      TX_DEFECT_O,
  input wire logic [NUM_MEAS-1:0][DLY_W-1:0] DELAY_O,
  input wire logic [NUM_MEAS-1:0]       DELAY_VALID_O,
  input wire logic [DLY_W:0]            SAMPLE_RTD_O,
  input wire logic                      CM_TX_FCS_VALID_O,
  input wire logic                      CM_RX_DONE_O,
  input wire logic [IQ_W-1:0]           IQ_O,
  input wire logic                      SYNC_DONE_O,
  input wire logic                      SYNC_TIMEOUT_O
);
  logic [31:0] wait_q;
  logic [31:0] wait_d;

  default clocking dc @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  // cycles spent negotiated but not yet synchronised
  always_comb wait_d = (ANEG_DONE_I && !SYNC_DONE_O) ? wait_q + 32'h1 : 32'h0;
  always_ff @(posedge SYS_CLK_I) wait_q <= RST_I ? 32'h0 : wait_d;

  sequence s_pin_low;
    (!RX_SIGNAL_OK_I) [*7];
  endsequence
  sequence s_pin_high;
    RX_SIGNAL_OK_I [*7];
  endsequence

  a_los_set: assert property (s_pin_low |-> ALARM_O.signal_lost)
    else $error("signal loss not flagged");
  a_los_clear: assert property (s_pin_high |-> !ALARM_O.signal_lost)
    else $error("signal loss flag stuck");
  a_rai_cause: assert property (TX_REMOTE_ALARM_O == (ALARM_O.signal_lost || ALARM_O.frame_lost))
    else $error("remote alarm out of step with loss flags");
  a_remote_masked: assert property (ALARM_O.frame_lost && $past(ALARM_O.frame_lost) |-> !ALARM_O.remote_alarm)
    else $error("remote alarm shown while unaligned");
  a_defect_or: assert property (!$past(RST_I) |-> TX_DEFECT_O == (|$past(SAP_FAULT_I)))
    else $error("defect output not the fault OR");
  a_delay_cause: assert property (DELAY_VALID_O != 4'h0 |-> (DELAY_VALID_O & ~$past(MEAS_STOP_I)) == 4'h0)
    else $error("delay result without stop");
  a_rtd_sum: assert property (!$past(RST_I) |->
    SAMPLE_RTD_O == {1'b0, $past(DELAY_O[2])} + {1'b0, $past(DELAY_O[3])})
    else $error("sample round trip not the sum");
  a_iq_plain: assert property (!$past(RST_I) |-> IQ_O == $past(IQ_I))
    else $error("sample word altered or late");
  a_tx_fcs: assert property (CM_TX_FCS_VALID_O |-> $past(CM_TX_I.valid) && $past(CM_TX_I.last))
    else $error("tx check sequence without last byte");
  a_rx_done: assert property (CM_RX_DONE_O |-> $past(CM_RX_I.valid) && $past(CM_RX_I.last))
    else $error("rx done without last byte");
  a_sync_bound: assert property (wait_q >= SYNC_LIMIT + 3 && ANEG_DONE_I && !SYNC_DONE_O |-> SYNC_TIMEOUT_O)
    else $error("start-up timeout missing");
  a_sync_clear: assert property (!$past(ANEG_DONE_I) && !$past(ANEG_DONE_I, 2) |-> !SYNC_TIMEOUT_O)
    else $error("timeout without negotiation");
endmodule

`default_nettype wire

// *** core/rla_link_supervisor.sv ***
// link supervision, alarms, delay calibration and management frame check
`timescale 1ns/100ps
`default_nettype none

module rla_link_supervisor
  import rla_pkg::*;
#(
  parameter int unsigned SYNC_LIMIT = SYNC_CYC
)
(
  input  wire logic                            SYS_CLK_I,
  input  wire logic                            RST_I,
  input  wire logic                            CE_I,
  input  wire logic                            RX_SIGNAL_OK_I,
  input  wire logic                            RX_FRAME_START_I,
  input  wire logic                            RX_REMOTE_ALARM_I,
  input  wire logic                            RX_DEFECT_I,
  input  wire logic [NUM_SAP-1:0]              SAP_FAULT_I,
  input  wire logic                            MEAS_EN_I,
  input  wire logic [NUM_MEAS-1:0]             MEAS_START_I,
  input  wire logic [NUM_MEAS-1:0]             MEAS_STOP_I,
  input  wire rla_cm_type                      CM_TX_I,
  input  wire rla_cm_type                      CM_RX_I,
  input  wire logic [IQ_W-1:0]                 IQ_I,
  input  wire logic                            ANEG_DONE_I,
  input  wire logic                            FREQ_LOCK_I,
  output rla_alarm_type                        ALARM_O,
  output logic                                 TX_REMOTE_ALARM_O,
  output logic                                 TX_DEFECT_O,
  output logic [NUM_MEAS-1:0][DLY_W-1:0]       DELAY_O,
  output logic [NUM_MEAS-1:0]                  DELAY_VALID_O,
  output logic [DLY_W:0]                       SAMPLE_RTD_O,
  output logic [FCS_W-1:0]                     CM_TX_FCS_O,
  output logic                                 CM_TX_FCS_VALID_O,
  output logic                                 CM_RX_DONE_O,
  output logic                                 CM_RX_FCS_ERR_O,
  output logic [IQ_W-1:0]                      IQ_O,
  output logic                                 SYNC_DONE_O,
  output logic                                 SYNC_TIMEOUT_O
);

  //**************************************************************************
  // signal detect input synchroniser
  //**************************************************************************
  logic sig1_q;
  logic sig2_q;
  logic sig3_q;
  logic los_q;
  logic los_d;

  always_comb
  begin
    los_d = los_q;
    // a change only counts once the last two stages agree
    if (sig2_q == sig3_q)
    begin
      los_d = ~sig3_q;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      sig1_q <= 1'b0;
      sig2_q <= 1'b0;
      sig3_q <= 1'b0;
      los_q  <= 1'b1;
    end
    else if (CE_I)
    begin
      sig1_q <= RX_SIGNAL_OK_I;
      sig2_q <= sig1_q;
      sig3_q <= sig2_q;
      los_q  <= los_d;
    end
  end

  //**************************************************************************
  // frame alignment
  //**************************************************************************
  rla_align_type        st_q;
  rla_align_type        st_d;
  logic [FRAME_W-1:0]   fcnt_q;
  logic [FRAME_W-1:0]   fcnt_d;
  logic [2:0]           k_q;
  logic [2:0]           k_d;
  logic                 slot;
  logic                 hit;
  logic                 miss;
  logic                 in_sync;

  assign slot    = (fcnt_q == FRAME_LAST);
  assign hit     = slot & RX_FRAME_START_I;
  assign miss    = slot ^ RX_FRAME_START_I;
  assign in_sync = (st_q == FA_SYNC) || (st_q == FA_SLIP);

  always_comb
  begin
    st_d   = st_q;
    k_d    = k_q;
    fcnt_d = slot ? '0 : fcnt_q + 16'h0001;
    unique case (st_q)
      FA_HUNT:
      begin
        if (RX_FRAME_START_I)
        begin
          st_d   = FA_VERIFY;
          fcnt_d = '0;
          k_d    = 3'h1;
        end
      end
      FA_VERIFY:
      begin
        if (hit)
        begin
          k_d = k_q + 3'h1;
          if ((k_q + 3'h1) == LOF_HIT)
          begin
            st_d = FA_SYNC;
          end
        end
        else if (miss)
        begin
          st_d = FA_HUNT;
        end
      end
      FA_SYNC:
      begin
        k_d = 3'h1;
        if (miss)
        begin
          st_d = FA_SLIP;
        end
      end
      FA_SLIP:
      begin
        if (hit)
        begin
          st_d = FA_SYNC;
        end
        else if (miss)
        begin
          k_d = k_q + 3'h1;
          if ((k_q + 3'h1) == LOF_MISS)
          begin
            st_d = FA_HUNT;
          end
        end
      end
    endcase
    // no frame can be trusted without light on the line
    if (los_q)
    begin
      st_d = FA_HUNT;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      st_q   <= FA_HUNT;
      fcnt_q <= '0;
      k_q    <= 3'h0;
    end
    else if (CE_I)
    begin
      st_q   <= st_d;
      fcnt_q <= fcnt_d;
      k_q    <= k_d;
    end
  end

  //**************************************************************************
  // alarm status and far-end indications
  //**************************************************************************
  rla_alarm_type alarm_q;
  rla_alarm_type alarm_d;
  logic          rai_q;
  logic          rai_d;
  logic          sdi_q;
  logic          sdi_d;

  always_comb
  begin
    alarm_d.signal_lost  = los_q;
    alarm_d.frame_lost   = ~in_sync;
    // received bits are meaningless until the frame is aligned
    alarm_d.remote_alarm = RX_REMOTE_ALARM_I & in_sync;
    alarm_d.defect       = RX_DEFECT_I & in_sync;
    rai_d                = los_q | ~in_sync;
    sdi_d                = |SAP_FAULT_I;
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      alarm_q <= '0;
      rai_q   <= 1'b0;
      sdi_q   <= 1'b0;
    end
    else if (CE_I)
    begin
      alarm_q <= alarm_d;
      rai_q   <= rai_d;
      sdi_q   <= sdi_d;
    end
  end

  assign ALARM_O           = alarm_q;
  assign TX_REMOTE_ALARM_O = rai_q;
  assign TX_DEFECT_O       = sdi_q;

  //**************************************************************************
  // round trip delay channels
  //**************************************************************************
  for (genvar g = 0; g < NUM_MEAS; g++)
  begin : g_meas
    logic             busy_q;
    logic             busy_d;
    logic [DLY_W-1:0] cnt_q;
    logic [DLY_W-1:0] cnt_d;
    logic [DLY_W-1:0] res_q;
    logic [DLY_W-1:0] res_d;
    logic             vld_q;
    logic             vld_d;

    always_comb
    begin
      busy_d = busy_q;
      cnt_d  = cnt_q;
      res_d  = res_q;
      vld_d  = 1'b0;
      if (busy_q)
      begin
        if (MEAS_STOP_I[g])
        begin
          busy_d = 1'b0;
          res_d  = cnt_q + 16'h0001;
          vld_d  = 1'b1;
        end
        else if (cnt_q == DLY_MAX)
        begin
          // lost echo: give up rather than report a wrapped count
          busy_d = 1'b0;
        end
        else
        begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      // each period's marker restarts the measurement
      if (MEAS_START_I[g] && MEAS_EN_I)
      begin
        busy_d = 1'b1;
        cnt_d  = '0;
      end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
      if (RST_I)
      begin
        busy_q <= 1'b0;
        cnt_q  <= '0;
        res_q  <= '0;
        vld_q  <= 1'b0;
      end
      else if (CE_I)
      begin
        busy_q <= busy_d;
        cnt_q  <= cnt_d;
        res_q  <= res_d;
        vld_q  <= vld_d;
      end
    end

    assign DELAY_O[g]       = res_q;
    assign DELAY_VALID_O[g] = vld_q;
  end

  logic [DLY_W:0] rtd_q;
  logic [DLY_W:0] rtd_d;

  always_comb
  begin
    rtd_d = {1'b0, g_meas[MEAS_DL].res_q} + {1'b0, g_meas[MEAS_UL].res_q};
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      rtd_q <= '0;
    end
    else if (CE_I)
    begin
      rtd_q <= rtd_d;
    end
  end

  assign SAMPLE_RTD_O = rtd_q;

  //**************************************************************************
  // management frame check sequence
  //**************************************************************************
  function automatic logic [FCS_W-1:0] fcs_byte(input logic [FCS_W-1:0] c,
                                                input logic [7:0]       d);
    logic [FCS_W-1:0] r;
    logic             fb;
    r = c;
    for (int k = 7; k >= 0; k--)
    begin
      fb = r[FCS_W-1] ^ d[k];
      r  = {r[FCS_W-2:0], 1'b0} ^ (fb ? FCS_POLY : '0);
    end
    return r;
  endfunction

  logic [FCS_W-1:0] tcrc_q;
  logic [FCS_W-1:0] tcrc_d;
  logic [FCS_W-1:0] tfcs_q;
  logic [FCS_W-1:0] tfcs_d;
  logic             tdone_q;
  logic             tdone_d;
  logic [FCS_W-1:0] rcrc_q;
  logic [FCS_W-1:0] rcrc_d;
  logic             rdone_q;
  logic             rdone_d;
  logic             rerr_q;
  logic             rerr_d;
  logic [FCS_W-1:0] tnext;
  logic [FCS_W-1:0] rnext;

  always_comb
  begin
    tnext   = fcs_byte(tcrc_q, CM_TX_I.data);
    rnext   = fcs_byte(rcrc_q, CM_RX_I.data);
    tcrc_d  = tcrc_q;
    tfcs_d  = tfcs_q;
    tdone_d = 1'b0;
    rcrc_d  = rcrc_q;
    rdone_d = 1'b0;
    rerr_d  = rerr_q;
    if (CM_TX_I.valid)
    begin
      tcrc_d = CM_TX_I.last ? FCS_INIT : tnext;
      if (CM_TX_I.last)
      begin
        tfcs_d  = tnext;
        tdone_d = 1'b1;
      end
    end
    // sequence bytes are run through too: a clean frame leaves zero
    if (CM_RX_I.valid)
    begin
      rcrc_d = CM_RX_I.last ? FCS_INIT : rnext;
      if (CM_RX_I.last)
      begin
        rerr_d  = (rnext != '0);
        rdone_d = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      tcrc_q  <= FCS_INIT;
      tfcs_q  <= '0;
      tdone_q <= 1'b0;
      rcrc_q  <= FCS_INIT;
      rdone_q <= 1'b0;
      rerr_q  <= 1'b0;
    end
    else if (CE_I)
    begin
      tcrc_q  <= tcrc_d;
      tfcs_q  <= tfcs_d;
      tdone_q <= tdone_d;
      rcrc_q  <= rcrc_d;
      rdone_q <= rdone_d;
      rerr_q  <= rerr_d;
    end
  end

  assign CM_TX_FCS_O       = tfcs_q;
  assign CM_TX_FCS_VALID_O = tdone_q;
  assign CM_RX_DONE_O      = rdone_q;
  assign CM_RX_FCS_ERR_O   = rerr_q;

  //**************************************************************************
  // user-plane samples and start-up supervision
  //**************************************************************************
  logic [IQ_W-1:0] iq_q;
  logic [31:0]     scnt_q;
  logic [31:0]     scnt_d;
  logic            sdone_q;
  logic            sdone_d;
  logic            sto_q;
  logic            sto_d;
  logic            synced;

  assign synced = FREQ_LOCK_I & in_sync;

  always_comb
  begin
    scnt_d  = scnt_q;
    sdone_d = ANEG_DONE_I & synced;
    sto_d   = 1'b0;
    // negotiation time is excluded: counting starts once it is done
    if (!ANEG_DONE_I || synced)
    begin
      scnt_d = '0;
    end
    else if (scnt_q >= SYNC_LIMIT)
    begin
      sto_d = 1'b1;
    end
    else
    begin
      scnt_d = scnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      iq_q    <= '0;
      scnt_q  <= '0;
      sdone_q <= 1'b0;
      sto_q   <= 1'b0;
    end
    else if (CE_I)
    begin
      iq_q    <= IQ_I;
      scnt_q  <= scnt_d;
      sdone_q <= sdone_d;
      sto_q   <= sto_d;
    end
  end

  assign IQ_O           = iq_q;
  assign SYNC_DONE_O    = sdone_q;
  assign SYNC_TIMEOUT_O = sto_q;

endmodule

`default_nettype wire

// *** core/rla_pkg.sv ***
// constants and carrier types of the link supervision and delay calibration block
//****************************************************************************
// How it works
// - every link's cable round trip delay is measured again on each period
// - per-link delay results leave on ports toward the baseband control unit
// - multi-hop round trip delay is measured directly, not summed
// - multi-hop result reaches the control unit as one end-to-end figure
// - signal loss and frame alignment loss are detected and flagged
// - signal or frame loss sends a remote alarm back to the far end
// - any faulty service access point sends a defect indication to the far end
// - all four alarms are handled here and exposed as status ports
// - sample round trip is downlink plus uplink edge-to-edge delay
// - user-plane samples pass with no protection added
// - management frames carry a 16-bit frame check sequence
// - synchronization must complete within 10 s after negotiation
//****************************************************************************
`default_nettype none

package rla_pkg;

  localparam int unsigned CLK_HZ       = 125000000;
  localparam int unsigned SYNC_TIME_S  = 10;
  localparam int unsigned SYNC_CYC     = SYNC_TIME_S * CLK_HZ;

  localparam int          FRAME_W      = 16;
  localparam logic [15:0] FRAME_LAST   = 16'h00FF;
  localparam logic [2:0]  LOF_HIT      = 3'h2;
  localparam logic [2:0]  LOF_MISS     = 3'h4;

  localparam int          NUM_SAP      = 4;
  localparam int          NUM_MEAS     = 4;
  localparam int          MEAS_LINK    = 0;
  localparam int          MEAS_MHOP    = 1;
  localparam int          MEAS_DL      = 2;
  localparam int          MEAS_UL      = 3;
  localparam int          DLY_W        = 16;
  localparam logic [15:0] DLY_MAX      = 16'hFFFE;

  localparam int          FCS_W        = 16;
  localparam logic [15:0] FCS_POLY     = 16'h1021;
  localparam logic [15:0] FCS_INIT     = 16'hFFFF;

  localparam int          IQ_W         = 32;

  typedef struct packed {
    logic signal_lost;
    logic frame_lost;
    logic remote_alarm;
    logic defect;
  } rla_alarm_type;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       last;
  } rla_cm_type;

  typedef enum logic [1:0] {
    FA_HUNT   = 2'b00,
    FA_VERIFY = 2'b01,
    FA_SYNC   = 2'b10,
    FA_SLIP   = 2'b11
  } rla_align_type;

endpackage

`default_nettype wire
